// File: usc_top.sv
// Control and status flags of the serial port with its shifters.
// Assumes a same-clock 16x baud tick and format bits from the mode
// register; the serial input pin is asynchronous and is synchronised.
`timescale 1ns/1ps
`default_nettype none
module usc_top
   import usc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       bit_wr,
   input  wire logic [7:0] bit_addr,
   input  wire logic       bit_val,
   input  wire logic       tx_load,
   input  wire logic [7:0] tx_wdata,
   input  wire logic       rx_pop,
   output logic      [7:0] rx_data,
   input  wire logic       baud_x16,
   input  wire logic       parity_enable,
   input  wire logic [1:0] parity_type_select,
   input  wire logic       extra_bit_enable,
   input  wire logic       multiproc_enable,
   input  wire logic       int_enable,
   input  wire logic       rxd,
   output logic            txd,
   output logic            irq
);
   import usc_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_EXTRA,
                             ST_STOP} usc_st_e;

   // ***********************************************************
   // Register write decode
   // ***********************************************************
   function automatic logic [7:0] wr_mask(input logic       bw,
                                          input logic [7:0] ba,
                                          input logic       sw,
                                          input logic [7:0] sa);
      wr_mask = '0;
      if (sw && sa == SCON_ADDR) begin
         wr_mask = 8'hFF;
      end else if (bw && ba[7:3] == SCON_BITBASE) begin
         wr_mask[ba[2:0]] = 1'b1; // R13
      end
   endfunction : wr_mask

   logic [7:0]  en, val;
   logic        extra_on;
   logic        rxd_s1_reg, rxd_s2_reg;
   usc_st_e     rx_st_reg, rx_st_next, tx_st_reg, tx_st_next;
   logic [3:0]  rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
   logic [2:0]  rx_bit_reg, rx_bit_next, tx_bit_reg, tx_bit_next;
   logic [7:0]  rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
   logic [7:0]  hold_reg, hold_next;
   logic        rx_x_reg, rx_x_next, tx_x_reg, tx_x_next;
   logic        txd_reg, txd_next;
   logic        rx_smp, tx_end, rx_done, push, take, ti_set;
   logic [ENT_W-1:0] ent, head;
   logic [1:0]  fcount;
   logic        ffull, fempty, chk_reg, chk_next;
   logic [7:0]  scon_reg, scon_next, rdata_reg, rdata_next;
   logic [7:0]  rxd_reg;
   logic        irq_reg, irq_next;

   assign en       = wr_mask(bit_wr, bit_addr, sfr_wr, sfr_addr);
   assign val      = (sfr_wr && sfr_addr == SCON_ADDR) ? sfr_wdata
                                                       : {8{bit_val}};
   assign extra_on = parity_enable | extra_bit_enable;

   // ***********************************************************
   // Receiver
   // ***********************************************************
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rxd_s1_reg <= 1'b1;
         rxd_s2_reg <= 1'b1;
      end else begin
         rxd_s1_reg <= rxd;
         rxd_s2_reg <= rxd_s1_reg;
      end
   end

   assign rx_smp  = baud_x16 && rx_cnt_reg == OVS_LAST;
   assign rx_done = rx_st_reg == ST_STOP && rx_smp;
   assign push    = rx_done && rxd_s2_reg && !ffull; // R14 R17
   // The extra slot holds the stop bit when parity is on.
   assign ent[DATA_W-1:0] = rx_sh_reg;
   assign ent[ENT_X] = (extra_bit_enable && !parity_enable) ? rx_x_reg
                                                           : rxd_s2_reg; // R7
   assign ent[ENT_P] = parity_enable &&
      (rx_x_reg != par_bit(rx_sh_reg, parity_type_select)); // R2 R15

   always_comb begin
      rx_st_next  = rx_st_reg;
      rx_cnt_next = baud_x16 ? 4'(rx_cnt_reg + 1'b1) : rx_cnt_reg;
      rx_bit_next = rx_bit_reg;
      rx_sh_next  = rx_sh_reg;
      rx_x_next   = rx_x_reg;
      case (rx_st_reg)
         ST_IDLE: begin
            rx_cnt_next = '0;
            if (scon_reg[B_REN] && !rxd_s2_reg) begin // R5
               rx_st_next = ST_START;
            end
         end
         ST_START: begin
            if (baud_x16 && rx_cnt_reg == OVS_HALF) begin
               rx_cnt_next = '0;
               rx_bit_next = '0;
               rx_st_next  = rxd_s2_reg ? ST_IDLE : ST_DATA; // R17
            end
         end
         ST_DATA: begin
            if (rx_smp) begin
               rx_sh_next  = {rxd_s2_reg, rx_sh_reg[7:1]};
               rx_bit_next = 3'(rx_bit_reg + 1'b1);
               if (rx_bit_reg == BIT_LAST) begin
                  rx_st_next = extra_on ? ST_EXTRA : ST_STOP;
               end
            end
         end
         ST_EXTRA: begin
            if (rx_smp) begin
               rx_x_next  = rxd_s2_reg;
               rx_st_next = ST_STOP;
            end
         end
         ST_STOP: begin
            if (rx_smp) begin
               rx_st_next = ST_IDLE;
            end
         end
         default: rx_st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_st_reg  <= ST_IDLE;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_sh_reg  <= '0;
         rx_x_reg   <= 1'b0;
      end else begin
         rx_st_reg  <= rx_st_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_bit_reg <= rx_bit_next;
         rx_sh_reg  <= rx_sh_next;
         rx_x_reg   <= rx_x_next;
      end
   end

   usc_rx_fifo #(
      .W     (ENT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk  (mclk),
      .nrst  (nrst),
      .push  (push),
      .din   (ent),
      .pop   (rx_pop),
      .dout  (head),
      .count (fcount),
      .full  (ffull),
      .empty (fempty)
   );

   // ***********************************************************
   // Transmitter
   // ***********************************************************
   assign tx_end = baud_x16 && tx_cnt_reg == OVS_LAST;
   assign take   = tx_st_reg == ST_IDLE && !scon_reg[B_THRE];

   always_comb begin
      tx_st_next  = tx_st_reg;
      tx_cnt_next = baud_x16 ? 4'(tx_cnt_reg + 1'b1) : tx_cnt_reg;
      tx_bit_next = tx_bit_reg;
      tx_sh_next  = tx_sh_reg;
      tx_x_next   = tx_x_reg;
      txd_next    = txd_reg;
      hold_next   = (tx_load && scon_reg[B_THRE]) ? tx_wdata : hold_reg;
      ti_set      = 1'b0;
      case (tx_st_reg)
         ST_IDLE: begin
            tx_cnt_next = '0;
            if (take) begin
               tx_sh_next = hold_reg;
               tx_x_next  = parity_enable ?
                  par_bit(hold_reg, parity_type_select) :
                  scon_reg[B_TBX]; // R6 R15
               txd_next   = 1'b0;
               tx_st_next = ST_START;
            end
         end
         ST_START: begin
            if (tx_end) begin
               txd_next    = tx_sh_reg[0];
               tx_bit_next = '0;
               tx_st_next  = ST_DATA;
            end
         end
         ST_DATA: begin
            if (tx_end) begin
               tx_sh_next  = {1'b0, tx_sh_reg[7:1]};
               tx_bit_next = 3'(tx_bit_reg + 1'b1);
               txd_next    = tx_sh_reg[1];
               if (tx_bit_reg == BIT_LAST) begin
                  txd_next   = extra_on ? tx_x_reg : 1'b1; // R17
                  tx_st_next = extra_on ? ST_EXTRA : ST_STOP;
                  ti_set     = !extra_on; // R8
               end
            end
         end
         ST_EXTRA: begin
            if (tx_end) begin
               txd_next   = 1'b1;
               tx_st_next = ST_STOP;
               ti_set     = 1'b1; // R8
            end
         end
         ST_STOP: begin
            if (tx_end) begin
               tx_st_next = ST_IDLE;
            end
         end
         default: tx_st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_st_reg  <= ST_IDLE;
         tx_cnt_reg <= '0;
         tx_bit_reg <= '0;
         tx_sh_reg  <= '0;
         tx_x_reg   <= 1'b0;
         txd_reg    <= 1'b1;
         hold_reg   <= '0;
      end else begin
         tx_st_reg  <= tx_st_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_bit_reg <= tx_bit_next;
         tx_sh_reg  <= tx_sh_next;
         tx_x_reg   <= tx_x_next;
         txd_reg    <= txd_next;
         hold_reg   <= hold_next;
      end
   end

   // ***********************************************************
   // Control and status register
   // ***********************************************************
   // A hardware set always beats a software clear in the same cycle.
   always_comb begin
      scon_next = (en & val) | (~en & scon_reg);
      scon_next[B_OVR] = (rx_done && rxd_s2_reg && ffull) |
                         scon_next[B_OVR]; // R1 R18
      // The oldest byte is judged once, the first cycle it is at the head.
      scon_next[B_PERR] = (parity_enable && !fempty && !chk_reg &&
                           head[ENT_P]) | scon_next[B_PERR]; // R2 R3
      scon_next[B_THRE] = (tx_load && scon_reg[B_THRE]) ? 1'b0 :
                          take ? 1'b1 : scon_reg[B_THRE]; // R4
      if (!fempty && !chk_reg) begin
         scon_next[B_RBX] = head[ENT_X]; // R7
      end
      scon_next[B_TI] = ti_set | scon_next[B_TI]; // R8 R12
      // A clear is refused while bytes wait behind the data buffer.
      scon_next[B_RI] = (push && (!multiproc_enable || rx_x_reg)) |
                        scon_next[B_RI] |
                        (scon_reg[B_RI] && fcount > 2'(1)); // R10 R11 R16
      chk_next   = !fempty && !rx_pop;
      irq_next   = int_enable && (scon_next[B_TI] || scon_next[B_RI]); // R9
      rdata_next = (sfr_rd && sfr_addr == SCON_ADDR) ? scon_reg : '0;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         scon_reg  <= SCON_RESET; // R13
         chk_reg   <= 1'b0;
         irq_reg   <= 1'b0;
         rdata_reg <= '0;
         rxd_reg   <= '0;
      end else begin
         scon_reg  <= scon_next;
         chk_reg   <= chk_next;
         irq_reg   <= irq_next;
         rdata_reg <= rdata_next;
         rxd_reg   <= head[DATA_W-1:0];
      end
   end

   assign sfr_rdata = rdata_reg;
   assign rx_data   = rxd_reg;
   assign txd       = txd_reg;
   assign irq       = irq_reg;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_drop_full;
      rx_done && rxd_s2_reg && ffull;
   endsequence
   sequence s_tx_to_stop;
      ti_set ##1 (tx_st_reg == ST_STOP);
   endsequence

   AST_OVR_ON_DROP: assert property (s_drop_full |=> scon_reg[B_OVR]) // R1
      else $error("overrun flag missed a dropped byte");
   AST_PERR_STICKY: assert property (scon_reg[B_PERR] && !(en[B_PERR]
      && !val[B_PERR]) |=> scon_reg[B_PERR]) // R3
      else $error("parity error flag cleared by hardware");
   AST_THRE_LOAD: assert property (tx_load && scon_reg[B_THRE]
      |=> !scon_reg[B_THRE] && hold_reg == $past(tx_wdata)) // R4
      else $error("holding register load not reflected");
   AST_REN_OFF: assert property (!scon_reg[B_REN] && rx_st_reg == ST_IDLE
      |=> rx_st_reg == ST_IDLE) // R5
      else $error("receiver started while disabled");
   AST_TX_EXTRA: assert property (tx_st_reg == ST_EXTRA |->
      txd_reg == tx_x_reg) // R6
      else $error("extra bit slot drives wrong level");
   AST_TI_AT_STOP: assert property (s_tx_to_stop |-> scon_reg[B_TI]
      && txd_reg) // R8
      else $error("done flag not set at stop bit");
   AST_IRQ: assert property (int_enable && (scon_reg[B_TI] ||
      scon_reg[B_RI]) && $stable(int_enable) |-> irq_reg) // R9
      else $error("interrupt request missing");
   AST_RI_SET: assert property (push && !multiproc_enable
      |=> scon_reg[B_RI] ##1 scon_reg[B_RI] || fcount <= 2'(1)) // R10
      else $error("available flag not set on accepted byte");
   AST_RI_HOLD: assert property (scon_reg[B_RI] && fcount > 2'(1)
      |=> scon_reg[B_RI]) // R11
      else $error("available flag cleared with bytes waiting");
   AST_MP_FILTER: assert property (push && multiproc_enable &&
      !rx_x_reg && !scon_reg[B_RI] && !en[B_RI] && fcount <= 2'(1)
      |=> !scon_reg[B_RI]) // R16
      else $error("available flag set on data byte in multiproc mode");
   AST_RESET: assert property (disable iff (1'b0)
      !nrst |=> scon_reg == SCON_RESET && irq_reg == 1'b0) // R13
      else $error("control register reset value wrong");
endmodule : usc_top
`default_nettype wire

// File: usc_pkg.sv
// Constants shared by the serial port control and status flag logic.
// Assumes one 100 MHz clock and a 16x oversampling tick from outside.
//
// Contract
// [R1] Overrun flag sets when a good character is dropped on a full FIFO.
// [R2] With parity on, error flag sets when the oldest byte mismatches.
// [R3] Hardware never clears the parity error flag; software writes it 0.
// [R4] Holding-empty flag is read-only; 1 means a byte may be written.
// [R5] Receive enable gates new characters; held bytes stay readable.
// [R6] Extra-bit option sends the transmit extra bit unless parity is on.
// [R7] Receive extra bit takes the extra bit, else the first stop bit.
// [R8] Transmit done flag sets at the start of the stop bit.
// [R9] With interrupt enabled, either done or available flag raises a request.
// [R10] Available flag sets as the stop bit of an accepted byte samples.
// [R11] Available flag stays 1 while bytes remain behind the data buffer.
// [R12] Hardware never clears the done or available flags itself.
// [R13] Register at 98h, bit-addressable; resets to 0 but empty flag 1.
// [R14] FIFO holds three bytes; bad stop or full FIFO drops the byte.
// [R15] Parity type 00 odd, 01 even, 10 mark, 11 space.
// [R16] Multiprocessor mode sets the available flag only on extra bit 1.
// [R17] Frame: low start, data LSB first, optional extra bit, high stop.
// [R18] Writing 0 clears the overrun flag; a same-cycle set wins.
`default_nettype none
package usc_pkg;
   localparam logic [7:0] SCON_ADDR   = 8'h98;
   localparam logic [4:0] SCON_BITBASE = 5'h13;
   localparam logic [7:0] SCON_RESET  = 8'h20;
   localparam int         B_OVR       = 7;
   localparam int         B_PERR      = 6;
   localparam int         B_THRE      = 5;
   localparam int         B_REN       = 4;
   localparam int         B_TBX       = 3;
   localparam int         B_RBX       = 2;
   localparam int         B_TI        = 1;
   localparam int         B_RI        = 0;
   localparam int         DATA_W      = 8;
   localparam int         ENT_X       = 8;
   localparam int         ENT_P       = 9;
   localparam int         ENT_W       = 10;
   localparam int         FIFO_DEPTH  = 3;
   localparam logic [3:0] OVS_LAST    = 4'hF;
   localparam logic [3:0] OVS_HALF    = 4'h7;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [1:0] PT_ODD      = 2'h0;
   localparam logic [1:0] PT_EVEN     = 2'h1;
   localparam logic [1:0] PT_MARK     = 2'h2;

   // Parity bit for a data byte under the selected type.
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [1:0] pt);
      case (pt)
         PT_ODD:  par_bit = ~^d; // R15
         PT_EVEN: par_bit = ^d;
         PT_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction : par_bit
endpackage : usc_pkg
`default_nettype wire

// File: usc_rx_fifo.sv
// Receive FIFO of flip-flops addressed by read and write indexes.
// Ignores push while full; the caller also drops such bytes.
`timescale 1ns/1ps
`default_nettype none
module usc_rx_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 3
) (
   input  wire logic                       mclk,
   input  wire logic                       nrst,
   input  wire logic                       push,
   input  wire logic [W-1:0]               din,
   input  wire logic                       pop,
   output logic      [W-1:0]               dout,
   output logic      [$clog2(DEPTH+1)-1:0] count,
   output logic                            full,
   output logic                            empty
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [W-1:0]  mem_next [DEPTH];
   logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic          do_push, do_pop;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
   endfunction : inc

   assign full    = (cnt_reg == CW'(DEPTH));
   assign empty   = (cnt_reg == '0);
   assign count   = cnt_reg;
   assign dout    = mem_reg[rp_reg];
   assign do_push = push & ~full; // R14
   assign do_pop  = pop & ~empty;

   always_comb begin
      mem_next = mem_reg;
      if (do_push) begin
         mem_next[wp_reg] = din;
      end
      wp_next  = do_push ? inc(wp_reg) : wp_reg;
      rp_next  = do_pop ? inc(rp_reg) : rp_reg;
      cnt_next = CW'(cnt_reg + CW'(do_push) - CW'(do_pop));
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         mem_reg <= mem_next;
      end
   end

   AST_FIFO_FULL_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      (full && !pop) |=> full && (wp_reg == $past(wp_reg))) // R14
      else $error("fifo took a byte while full");
endmodule : usc_rx_fifo
`default_nettype wire

// File: usc_remote_node.sv
// Model of the remote serial node facing the port: it sends frames into
// the receive pin and decodes the frames coming out of the transmit pin.
// Assumes the port's bit time is BIT_CYC clocks of mclk.
`timescale 1ns/1ps
`default_nettype none
module usc_remote_node #(
   parameter int BIT_CYC = 64
) (
   input  wire logic       mclk,
   input  wire logic       line_in,
   input  wire logic       has_extra,
   output logic            line_out,
   output logic      [7:0] got_data,
   output logic            got_extra,
   output logic            got_stop,
   output int              got_cnt
);
   // ***************************************************************
   // Frame sender and frame decoder
   // ***************************************************************
   initial begin
      line_out = 1'b1;
      got_data = 8'h00;
      got_extra = 1'b0;
      got_stop = 1'b0;
      got_cnt = 0;
   end

   // The line is driven high at start and after each frame, so it rests high between frames.
   task automatic send(input logic [7:0] d, input logic x,
                       input logic hx, input logic stp);
      int i;
      line_out <= 1'b0;
      repeat (BIT_CYC) @(posedge mclk);
      for (i = 0; i < 8; i++) begin
         line_out <= d[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
      if (hx) begin
         line_out <= x;
         repeat (BIT_CYC) @(posedge mclk);
      end
      // A bad stop bit ends soon after its sampling point; a full low
      // bit would make the receiver take its tail for a new start bit.
      line_out <= stp;
      repeat (stp ? BIT_CYC : 3 * BIT_CYC / 4) @(posedge mclk);
      line_out <= 1'b1;
      repeat (stp ? BIT_CYC : 5 * BIT_CYC / 4) @(posedge mclk);
   endtask : send

   // Samples mid-bit; the count rises at the middle of the stop bit.
   always begin : rx_frames
      int i;
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge mclk);
         got_data[i] = line_in;
      end
      if (has_extra) begin
         repeat (BIT_CYC) @(posedge mclk);
         got_extra = line_in;
      end
      repeat (BIT_CYC) @(posedge mclk);
      got_stop = line_in;
      got_cnt++;
   end
endmodule : usc_remote_node
`default_nettype wire

// File: usc_top_tb.sv
// Self-checking bench for the serial port control and status flags.
// Assumes usc_top and usc_remote_node; one baud tick every 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module usc_top_tb;
   // ***************************************************************
   // Stimulus, checks and scenarios
   // ***************************************************************
   localparam logic [3:0] PAR01 = 4'b0110;
   logic       mclk, nrst, sfr_wr, sfr_rd, bit_wr, bit_val, tx_load, rx_pop;
   logic       baud_x16, parity_enable, extra_bit_enable, multiproc_enable;
   logic       int_enable, rxd, txd, irq, has_x, got_extra, got_stop;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, tx_wdata, rx_data;
   logic [7:0] got_data, v;
   logic [1:0] parity_type_select, div;
   int         got_cnt, error_cnt, tests_run;

   assign has_x = parity_enable | extra_bit_enable;

   usc_top dut (
      .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_val(bit_val),
      .tx_load(tx_load), .tx_wdata(tx_wdata), .rx_pop(rx_pop),
      .rx_data(rx_data), .baud_x16(baud_x16),
      .parity_enable(parity_enable),
      .parity_type_select(parity_type_select),
      .extra_bit_enable(extra_bit_enable),
      .multiproc_enable(multiproc_enable), .int_enable(int_enable),
      .rxd(rxd), .txd(txd), .irq(irq)
   );

   usc_remote_node #(.BIT_CYC(64)) node (
      .mclk(mclk), .line_in(txd), .has_extra(has_x), .line_out(rxd),
      .got_data(got_data), .got_extra(got_extra), .got_stop(got_stop),
      .got_cnt(got_cnt)
   );

   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   always @(posedge mclk) begin
      div <= div + 2'h1;
      baud_x16 <= (div == 2'h3);
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Read data stands for one cycle only, so it is taken right then.
   task automatic rd(input logic [7:0] a);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 v = sfr_rdata;
   endtask : rd

   task automatic chkreg(input logic [7:0] exp, input logic [7:0] m);
      rd(8'h98);
      chk("status", v & m, exp & m);
   endtask : chkreg

   task automatic wr_bit(input logic [2:0] n, input logic b);
      bit_addr <= 8'h98 + {5'h00, n};
      bit_val <= b;
      bit_wr <= 1'b1;
      @(posedge mclk);
      bit_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_bit

   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_byte

   task automatic tx_go(input logic [7:0] d);
      tx_wdata <= d;
      tx_load <= 1'b1;
      @(posedge mclk);
      tx_load <= 1'b0;
      @(posedge mclk);
   endtask : tx_go

   task automatic pop();
      rx_pop <= 1'b1;
      @(posedge mclk);
      rx_pop <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask : pop

   task automatic tx_check(input logic [7:0] d, input logic x);
      int c0;
      int k;
      c0 = got_cnt;
      for (k = 0; k < 2000 && got_cnt == c0; k++) @(posedge mclk);
      chk("frames", 8'(got_cnt - c0), 8'h01);
      chk("tx data", got_data, d);
      chk("tx extra", {7'h00, got_extra}, {7'h00, x});
      chk("tx stop", {7'h00, got_stop}, 8'h01);
   endtask : tx_check

   task automatic t_reset();
      chkreg(8'h20, 8'hFF);
      rd(8'h80);
      chk("unmapped", v, 8'h00);
      wr_bit(3'h5, 1'b0);
      chkreg(8'h20, 8'hFF);
      wr_byte(8'h80, 8'hFF);
      chkreg(8'h20, 8'hFF);
      $display("test reset done");
   endtask : t_reset

   task automatic t_tx();
      int pt;
      int_enable <= 1'b1;
      extra_bit_enable <= 1'b1;
      wr_bit(3'h3, 1'b1);
      tx_go(8'h3C);
      repeat (4) @(posedge mclk);
      tx_go(8'hC3);
      chkreg(8'h08, 8'hFF);
      tx_check(8'h3C, 1'b1);
      tx_check(8'hC3, 1'b1);
      chkreg(8'h2A, 8'hFF);
      chk("irq", {7'h00, irq}, 8'h01);
      wr_bit(3'h1, 1'b0);
      chkreg(8'h28, 8'hFF);
      chk("irq", {7'h00, irq}, 8'h00);
      parity_enable <= 1'b1;
      for (pt = 0; pt < 4; pt++) begin
         parity_type_select <= pt[1:0];
         tx_go(8'h01);
         tx_check(8'h01, PAR01[pt]);
      end
      parity_enable <= 1'b0;
      wr_bit(3'h1, 1'b0);
      wr_bit(3'h3, 1'b0);
      $display("test transmit done");
   endtask : t_tx

   task automatic t_rx();
      node.send(8'h5A, 1'b0, has_x, 1'b1);
      chkreg(8'h20, 8'hFF);
      wr_byte(8'h98, 8'h10);
      node.send(8'h5A, 1'b0, has_x, 1'b1);
      chkreg(8'h31, 8'hFF);
      chk("rx data", rx_data, 8'h5A);
      chk("irq", {7'h00, irq}, 8'h01);
      wr_bit(3'h0, 1'b0);
      chkreg(8'h30, 8'hFF);
      wr_bit(3'h4, 1'b0);
      chk("rx data", rx_data, 8'h5A);
      pop();
      wr_bit(3'h4, 1'b1);
      extra_bit_enable <= 1'b0;
      node.send(8'hC3, 1'b0, 1'b0, 1'b1);
      chkreg(8'h35, 8'hFF);
      pop();
      wr_bit(3'h0, 1'b0);
      $display("test receive done");
   endtask : t_rx

   task automatic t_ovr();
      int i;
      for (i = 0; i < 4; i++) node.send(8'h10 + 8'(i), 1'b0, has_x, 1'b1);
      chkreg(8'hB1, 8'hFB);
      chk("rx data", rx_data, 8'h10);
      wr_bit(3'h0, 1'b0);
      chkreg(8'hB1, 8'hFB);
      wr_bit(3'h7, 1'b0);
      chkreg(8'h31, 8'hFB);
      pop();
      chk("rx data", rx_data, 8'h11);
      pop();
      chk("rx data", rx_data, 8'h12);
      wr_bit(3'h0, 1'b0);
      chkreg(8'h30, 8'hFB);
      pop();
      node.send(8'h77, 1'b0, has_x, 1'b0);
      chkreg(8'h30, 8'hFB);
      $display("test overrun done");
   endtask : t_ovr

   task automatic t_par();
      parity_enable <= 1'b1;
      parity_type_select <= 2'h1;
      @(posedge mclk);
      node.send(8'h01, 1'b0, has_x, 1'b1);
      chkreg(8'h71, 8'hFB);
      pop();
      wr_bit(3'h0, 1'b0);
      node.send(8'h01, 1'b1, has_x, 1'b1);
      chkreg(8'h71, 8'hFB);
      wr_bit(3'h6, 1'b0);
      chkreg(8'h31, 8'hFB);
      pop();
      wr_bit(3'h0, 1'b0);
      parity_enable <= 1'b0;
      $display("test parity done");
   endtask : t_par

   task automatic t_mp();
      multiproc_enable <= 1'b1;
      extra_bit_enable <= 1'b1;
      @(posedge mclk);
      node.send(8'h22, 1'b0, has_x, 1'b1);
      chkreg(8'h30, 8'hFB);
      pop();
      node.send(8'h44, 1'b1, has_x, 1'b1);
      chkreg(8'h35, 8'hFF);
      pop();
      wr_bit(3'h0, 1'b0);
      multiproc_enable <= 1'b0;
      $display("test multiprocessor done");
   endtask : t_mp

   // Eighteen frames of about 800 clocks each fit well inside this span.
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      {nrst, sfr_wr, sfr_rd, bit_wr, bit_val, tx_load, rx_pop} = 7'h00;
      {baud_x16, parity_enable, extra_bit_enable} = 3'h0;
      {multiproc_enable, int_enable} = 2'h0;
      {sfr_addr, sfr_wdata, bit_addr, tx_wdata} = 32'h0;
      parity_type_select = 2'h0;
      div = 2'h0;
      error_cnt = 0;
      tests_run = 0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_tx();
      t_rx();
      t_ovr();
      t_par();
      t_mp();
      close_out();
   end
endmodule : usc_top_tb
`default_nettype wire
